// ===== verilog/clk_select_pkg.sv
// Constants, types and decode helpers for the clock source select block
// Summary of operation
// - Bits six to four of the select register choose the USB clock source.
// - USB codes: mult, int/2, ext, ext/2, ext/3, ext/4; 110 and 111 reserved.
// - Bits two to zero of the select register choose the system clock source.
// - System codes: int, ext, mult/2, mult, low-freq osc; 101 to 111 reserved.
// - The undivided multiplier system code exists only on 48 MHz variants.
// - Bits seven and three read as zero and ignore writes.
package clk_select_pkg;

    // ========================================================================
    // Register map
    localparam int          ADDR_W          = 10;
    localparam logic [7:0]  SEL_IDX         = 8'ha9;
    localparam logic [7:0]  STATUS_IDX      = 8'haa;
    localparam logic [7:0]  SEL_RESET       = 8'h00;
    localparam int          USB_LSB         = 4;
    localparam int          SYS_LSB         = 0;
    localparam int          STAT_USB_LSB    = 4;
    localparam int          STAT_SYS_PEND   = 8;
    localparam int          STAT_USB_PEND   = 9;

    // ========================================================================
    // Source codes
    localparam logic [2:0]  USB_MULT        = 3'h0;
    localparam logic [2:0]  USB_INT_DIV2    = 3'h1;
    localparam logic [2:0]  USB_EXT         = 3'h2;
    localparam logic [2:0]  USB_EXT_DIV2    = 3'h3;
    localparam logic [2:0]  USB_EXT_DIV3    = 3'h4;
    localparam logic [2:0]  USB_EXT_DIV4    = 3'h5;
    localparam logic [2:0]  SYS_INT         = 3'h0;
    localparam logic [2:0]  SYS_EXT         = 3'h1;
    localparam logic [2:0]  SYS_MULT_DIV2   = 3'h2;
    localparam logic [2:0]  SYS_MULT        = 3'h3;
    localparam logic [2:0]  SYS_LFO         = 3'h4;

    // ========================================================================
    // Dividers: source index and ratio per divided tick
    localparam int          NUM_DIV         = 5;
    localparam int          DIV_INT2        = 0;
    localparam int          DIV_EXT2        = 1;
    localparam int          DIV_EXT3        = 2;
    localparam int          DIV_EXT4        = 3;
    localparam int          DIV_MULT2       = 4;
    localparam int          SRC_INT         = 0;
    localparam int          SRC_EXT         = 1;
    localparam int          SRC_MULT        = 2;
    localparam int          DIV_SRC [NUM_DIV]   = '{0, 1, 1, 1, 2};
    localparam int          DIV_RATIO [NUM_DIV] = '{2, 2, 3, 4, 2};

    // ========================================================================
    // Source tick bundle, one-cycle pulse per source clock period
    typedef struct packed {
        logic lfo;
        logic mult;
        logic ext_osc;
        logic int_osc;
    } src_ticks_type;

    // USB decode, reserved codes select nothing
    function automatic logic usb_tick(input logic [2:0] code,
                                      input src_ticks_type t,
                                      input logic [NUM_DIV-1:0] dv);
        unique case (code)
            USB_MULT:     usb_tick = t.mult;
            USB_INT_DIV2: usb_tick = dv[DIV_INT2];
            USB_EXT:      usb_tick = t.ext_osc;
            USB_EXT_DIV2: usb_tick = dv[DIV_EXT2];
            USB_EXT_DIV3: usb_tick = dv[DIV_EXT3];
            USB_EXT_DIV4: usb_tick = dv[DIV_EXT4];
            default:      usb_tick = 1'b0;
        endcase
    endfunction

    // System decode, reserved codes select nothing
    function automatic logic sys_tick(input logic [2:0] code,
                                      input src_ticks_type t,
                                      input logic [NUM_DIV-1:0] dv);
        unique case (code)
            SYS_INT:       sys_tick = t.int_osc;
            SYS_EXT:       sys_tick = t.ext_osc;
            SYS_MULT_DIV2: sys_tick = dv[DIV_MULT2];
            SYS_MULT:      sys_tick = t.mult;
            SYS_LFO:       sys_tick = t.lfo;
            default:       sys_tick = 1'b0;
        endcase
    endfunction

endpackage

// ===== verilog/tick_divider.sv
// Divides a one-cycle source tick by a fixed ratio
`timescale 1ns/1ps
module tick_divider
    import clk_select_pkg::*;
#(
    parameter int RATIO = 2
) (
    input  wire logic clk_sys_i,
    input  wire logic arst_n_i,
    input  wire logic tick_i,
    output logic      tick_o
);

    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic       tick_q;
    logic       tick_d;

    // ========================================================================
    // Counter
    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (tick_i) begin
            if (cnt_q == 3'(RATIO - 1)) begin
                cnt_d  = 3'h0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q  <= 3'h0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;

endmodule

// ===== verilog/clk_select.sv
// System and USB clock source select with register slave
`timescale 1ns/1ps
module clk_select
    import clk_select_pkg::*;
#(
    parameter bit MULT_SYS_AVAIL = 1'b1
) (
    input  wire logic              clk_sys_i,
    input  wire logic              arst_n_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire src_ticks_type     src_ticks_i,
    output logic                   sys_clk_en_o,
    output logic                   usb_clk_en_o
);

    logic [2:0]         usb_sel_q;
    logic [2:0]         usb_sel_d;
    logic [2:0]         sys_sel_q;
    logic [2:0]         sys_sel_d;
    logic               ack_q;
    logic               ack_d;
    logic [31:0]        rdata_q;
    logic [31:0]        rdata_d;
    logic [2:0]         sys_act_q;
    logic [2:0]         sys_act_d;
    logic [2:0]         usb_act_q;
    logic [2:0]         usb_act_d;
    logic               sys_en_q;
    logic               sys_en_d;
    logic               usb_en_q;
    logic               usb_en_d;
    logic [NUM_DIV-1:0] div_ticks;
    logic [2:0]         src_vec;
    logic               sys_req_ok;
    logic               usb_req_ok;
    logic               sys_pend;
    logic               usb_pend;
    logic [7:0]         idx;

    // ========================================================================
    // Dividers
    assign src_vec = {src_ticks_i.mult, src_ticks_i.ext_osc,
                      src_ticks_i.int_osc};

    for (genvar g = 0; g < NUM_DIV; g++) begin : g_div
        tick_divider #(
            .RATIO (DIV_RATIO[g])
        ) u_div (
            .clk_sys_i (clk_sys_i),
            .arst_n_i  (arst_n_i),
            .tick_i    (src_vec[DIV_SRC[g]]),
            .tick_o    (div_ticks[g])
        );
    end

    // ========================================================================
    // Register slave
    assign idx               = avs_address_i[ADDR_W-1:2];
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign avs_readdata_o    = rdata_q;

    always_comb begin
        usb_sel_d = usb_sel_q;
        sys_sel_d = sys_sel_q;
        ack_d     = (avs_read_i | avs_write_i) & ~ack_q;
        rdata_d   = rdata_q;
        // Write lands at the edge that sees waitrequest low
        if (ack_q && avs_write_i && idx == SEL_IDX) begin
            usb_sel_d = avs_writedata_i[USB_LSB +: 3];
            sys_sel_d = avs_writedata_i[SYS_LSB +: 3];
        end
        if (ack_d && avs_read_i) begin
            rdata_d = 32'h0;
            unique case (idx)
                SEL_IDX: begin
                    // Bits 7 and 3 stay zero
                    rdata_d[USB_LSB +: 3] = usb_sel_q;
                    rdata_d[SYS_LSB +: 3] = sys_sel_q;
                end
                STATUS_IDX: begin
                    rdata_d[SYS_LSB +: 3]      = sys_act_q;
                    rdata_d[STAT_USB_LSB +: 3] = usb_act_q;
                    rdata_d[STAT_SYS_PEND]     = sys_pend;
                    rdata_d[STAT_USB_PEND]     = usb_pend;
                end
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            usb_sel_q <= SEL_RESET[USB_LSB +: 3];
            sys_sel_q <= SEL_RESET[SYS_LSB +: 3];
            ack_q     <= 1'b0;
            rdata_q   <= 32'h0;
        end else begin
            usb_sel_q <= usb_sel_d;
            sys_sel_q <= sys_sel_d;
            ack_q     <= ack_d;
            rdata_q   <= rdata_d;
        end
    end

    // ========================================================================
    // Glitch-free muxes: hold off until the new source ticks
    always_comb begin
        sys_req_ok = (sys_sel_q <= SYS_LFO);
        if (sys_sel_q == SYS_MULT && !MULT_SYS_AVAIL) begin
            sys_req_ok = 1'b0;
        end
        usb_req_ok = (usb_sel_q <= USB_EXT_DIV4);
        sys_pend   = sys_req_ok && (sys_sel_q != sys_act_q);
        usb_pend   = usb_req_ok && (usb_sel_q != usb_act_q);
        sys_act_d  = sys_act_q;
        usb_act_d  = usb_act_q;
        sys_en_d   = sys_tick(sys_act_q, src_ticks_i, div_ticks);
        usb_en_d   = usb_tick(usb_act_q, src_ticks_i, div_ticks);
        if (sys_pend) begin
            sys_en_d = sys_tick(sys_sel_q, src_ticks_i, div_ticks);
            if (sys_en_d) begin
                sys_act_d = sys_sel_q;
            end
        end
        if (usb_pend) begin
            usb_en_d = usb_tick(usb_sel_q, src_ticks_i, div_ticks);
            if (usb_en_d) begin
                usb_act_d = usb_sel_q;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sys_act_q <= SEL_RESET[SYS_LSB +: 3];
            usb_act_q <= SEL_RESET[USB_LSB +: 3];
            sys_en_q  <= 1'b0;
            usb_en_q  <= 1'b0;
        end else begin
            sys_act_q <= sys_act_d;
            usb_act_q <= usb_act_d;
            sys_en_q  <= sys_en_d;
            usb_en_q  <= usb_en_d;
        end
    end

    assign sys_clk_en_o = sys_en_q;
    assign usb_clk_en_o = usb_en_q;

    // ========================================================================
    // Assertions
    sequence s_select_wr;
        avs_write_i && !avs_waitrequest_o && idx == SEL_IDX;
    endsequence

    sequence s_usb_switch;
        usb_pend && usb_tick(usb_sel_q, src_ticks_i, div_ticks);
    endsequence

    property p_usb_field;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        s_select_wr |=> usb_sel_q == $past(avs_writedata_i[6:4]);
    endproperty
    a_usb_field: assert property (p_usb_field)
        else $error("usb field not stored from bits 6..4");

    property p_sys_field;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        s_select_wr |=> sys_sel_q == $past(avs_writedata_i[2:0]);
    endproperty
    a_sys_field: assert property (p_sys_field)
        else $error("sys field not stored from bits 2..0");

    property p_usb_reserved;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        usb_sel_q[2:1] == 2'b11 |=> usb_act_q == $past(usb_act_q);
    endproperty
    a_usb_reserved: assert property (p_usb_reserved)
        else $error("reserved usb code changed active source");

    property p_usb_ext;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (usb_act_q == USB_EXT && !usb_pend)
            |=> usb_clk_en_o == $past(src_ticks_i.ext_osc);
    endproperty
    a_usb_ext: assert property (p_usb_ext)
        else $error("usb ext source not passed through");

    property p_sys_reserved;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        sys_act_q <= SYS_LFO;
    endproperty
    a_sys_reserved: assert property (p_sys_reserved)
        else $error("system source took a reserved code");

    property p_sys_int;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (sys_act_q == SYS_INT && !sys_pend)
            |=> sys_clk_en_o == $past(src_ticks_i.int_osc);
    endproperty
    a_sys_int: assert property (p_sys_int)
        else $error("system int source not passed through");

    property p_mult_avail;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        !MULT_SYS_AVAIL |-> sys_act_q != SYS_MULT;
    endproperty
    a_mult_avail: assert property (p_mult_avail)
        else $error("undivided multiplier used on a variant without it");

    property p_unused_bits;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (avs_read_i && ack_d && idx == SEL_IDX)
            |=> avs_readdata_o[7] == 1'b0 && avs_readdata_o[3] == 1'b0;
    endproperty
    a_unused_bits: assert property (p_unused_bits)
        else $error("unused select bits read nonzero");

    property p_clean_switch;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        s_usb_switch |=> usb_clk_en_o && usb_act_q == $past(usb_sel_q);
    endproperty
    a_clean_switch: assert property (p_clean_switch)
        else $error("usb switch not made on a whole new-source tick");

endmodule

// ===== sim/testbench.sv
// Self-checking testbench for the clock source select block
`timescale 1ns/1ps
module testbench
    import clk_select_pkg::*;
;
    // ========================================================================
    // Signals and bookkeeping
    logic              clk_sys_i;
    logic              arst_n_i;
    logic [ADDR_W-1:0] avs_address_i;
    logic              avs_read_i;
    logic              avs_write_i;
    logic [31:0]       avs_writedata_i;
    logic [31:0]       avs_readdata_o;
    logic              avs_waitrequest_o;
    src_ticks_type     src_ticks_i;
    logic              sys_clk_en_o;
    logic              usb_clk_en_o;
    logic              sys_en_nomult;
    logic [2:0]        sys_act;
    logic [2:0]        usb_act;
    logic [2:0]        sys_act2;
    int                err_count = 0;
    int                samples_checked = 0;
    int                sys_cnt = 0;
    int                usb_cnt = 0;
    int                sys2_cnt = 0;

    localparam logic [ADDR_W-1:0] A_SEL  = {SEL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_STAT = {STATUS_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] A_NONE = 10'h3fc;
    localparam int SYS_SRC [5] = '{0, 1, 2, 2, 3};
    localparam int SYS_DIV [5] = '{1, 1, 2, 1, 1};
    localparam int USB_SRC [6] = '{2, 0, 1, 1, 1, 1};
    localparam int USB_DIV [6] = '{1, 2, 1, 2, 3, 4};
    localparam logic [7:0] CFG [10] = '{8'h21, 8'h12, 8'h33, 8'h44,
                                        8'h50, 8'hfd, 8'h6f,
                                        8'h03, 8'h83, 8'h00};

    // ========================================================================
    // Design instances
    clk_select DUT (
        .clk_sys_i         (clk_sys_i),
        .arst_n_i          (arst_n_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .src_ticks_i       (src_ticks_i),
        .sys_clk_en_o      (sys_clk_en_o),
        .usb_clk_en_o      (usb_clk_en_o)
    );

    clk_select #(.MULT_SYS_AVAIL(1'b0)) DUT_NOMULT (
        .clk_sys_i         (clk_sys_i),
        .arst_n_i          (arst_n_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_readdata_o    (),
        .avs_waitrequest_o (),
        .src_ticks_i       (src_ticks_i),
        .sys_clk_en_o      (sys_en_nomult),
        .usb_clk_en_o      ()
    );

    // ========================================================================
    // Clock, pulse counters, watchdog
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        if (sys_clk_en_o === 1'b1) sys_cnt <= sys_cnt + 1;
        if (usb_clk_en_o === 1'b1) usb_cnt <= usb_cnt + 1;
        if (sys_en_nomult === 1'b1) sys2_cnt <= sys2_cnt + 1;
    end

    initial begin
        #100us;
        err_count++;
        results();
    end

    // ========================================================================
    // Shared tasks
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [7:0] d, output logic [31:0] rd);
        int n;
        avs_address_i   <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0);
        check("avs_waitrequest_o cycles", n, 32'd2);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic burst(input int b);
        int s0;
        int u0;
        int s2;
        s0 = sys_cnt;
        u0 = usb_cnt;
        s2 = sys2_cnt;
        repeat (12) begin
            src_ticks_i <= src_ticks_type'(4'h1 << b);
            @(posedge clk_sys_i);
            src_ticks_i <= '0;
            @(posedge clk_sys_i);
        end
        repeat (4) @(posedge clk_sys_i);
        check("sys_clk_en_o pulses", sys_cnt - s0,
              (SYS_SRC[sys_act] == b) ? 12 / SYS_DIV[sys_act] : 0);
        check("usb_clk_en_o pulses", usb_cnt - u0,
              (USB_SRC[usb_act] == b) ? 12 / USB_DIV[usb_act] : 0);
        check("nomult sys pulses", sys2_cnt - s2,
              (SYS_SRC[sys_act2] == b) ? 12 / SYS_DIV[sys_act2] : 0);
    endtask

    // ========================================================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] rd;
        bus(1'b0, A_SEL, 8'h00, rd);
        check("clock_source_select reset", rd, 32'h0);
        bus(1'b0, A_STAT, 8'h00, rd);
        check("status reset", rd, 32'h0);
        for (int b = 0; b < 4; b++) burst(b);
    endtask

    task automatic t_unmapped();
        logic [31:0] rd;
        bus(1'b1, A_NONE, 8'hff, rd);
        bus(1'b0, A_NONE, 8'h00, rd);
        check("unmapped read", rd, 32'h0);
        bus(1'b0, A_SEL, 8'h00, rd);
        check("clock_source_select kept", rd, 32'h0);
    endtask

    task automatic t_select();
        logic [31:0] rd;
        logic [7:0]  d;
        for (int i = 0; i < 10; i++) begin
            d = CFG[i];
            bus(1'b1, A_SEL, d, rd);
            if (d[2:0] <= 3'h4) sys_act = d[2:0];
            if (d[6:4] <= 3'h5) usb_act = d[6:4];
            if (d[2:0] <= 3'h4 && d[2:0] != 3'h3) sys_act2 = d[2:0];
            bus(1'b0, A_SEL, 8'h00, rd);
            check("clock_source_select", rd, {24'h0, d & 8'h77});
            for (int b = 0; b < 4; b++) burst(b);
            bus(1'b0, A_STAT, 8'h00, rd);
            check("status", rd, {25'h0, usb_act, 1'b0, sys_act});
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ========================================================================
    // Main sequence
    initial begin
        arst_n_i        = 1'b0;
        avs_address_i   = '0;
        avs_read_i      = 1'b0;
        avs_write_i     = 1'b0;
        avs_writedata_i = 32'h0;
        src_ticks_i     = '0;
        sys_act         = 3'h0;
        usb_act         = 3'h0;
        sys_act2        = 3'h0;
        repeat (8) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        t_reset();
        t_unmapped();
        t_select();
        results();
    end
endmodule
